// ### rsseq_sequencer.sv
// Rail strobe sequencer: strobe timing, slot decode and configuration registers
// Notes on behaviour
// - Delay n sits between strobe n and strobe n+1 so strobes 1 to 10 come in order.
// - Each delay has its own select bit, zero giving 2 ms and one giving 5 ms.
// - The ninth delay select is bit 0 of its own register apart from the first eight.
// - After reset delays 2 and 3 select 5 ms and all others 2 ms.
// - With the stretch bit set every delay is ten times longer during power-down.
// - The stretch bit never alters power-up delays.
// - Slot codes 3h to Ah enable a converter at strobes 3 to 10.
// - Slot codes 0h to 2h and Bh to Fh leave a converter untouched by strobes.
// - Converters one and two use bits 3-0 and 7-4 of one register, three and four of the next.
// - After reset the slots are strobe 4, 9, 10 and 8 for converters one to four.
// - Strobes 1 and 2 are issued only while the freshness seal flag is zero.
`timescale 1ns/1ps
`default_nettype none
module rsseq_sequencer
    import rsseq_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Register access from the serial interface engine
    input wire rsseq_reg_req_s i_reg_req,
    output logic [7:0] o_reg_rdata,
    // Sequence control
    input wire logic i_pu_start,
    input wire logic i_pd_start,
    input wire logic i_freshness_seal_flag,
    output logic o_busy,
    // Strobe and rail enables
    output logic o_strobe_pulse,
    output logic [3:0] o_strobe_num,
    output logic [NUM_CONV-1:0] o_rail_en
);
    logic [7:0] gaps_reg;
    logic gap9_reg;
    logic powerdown_stretch_reg;
    logic [7:0] slot_c12_reg;
    logic [7:0] slot_c34_reg;
    rsseq_state_e state_reg;
    logic down_reg;
    logic [3:0] cur_reg;
    logic [5:0] ms_reg;
    logic [5:0] ms_next;
    logic [$clog2(CYC_MS+1)-1:0] div_reg;
    logic tick;
    logic [NUM_GAPS-1:0] gap_sel;
    logic [3:0] gap_idx;
    logic [SLOT_W*NUM_CONV-1:0] slots;
    logic [NUM_CONV-1:0] hit;

    assign slots = {slot_c34_reg, slot_c12_reg};
    assign gap_sel = {gap9_reg, gaps_reg};
    assign tick = (div_reg == ($clog2(CYC_MS+1))'(CYC_MS - 1));

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            gaps_reg <= RST_GAPS_1_8;
            gap9_reg <= RST_GAP9_FCTR[GAP9_BIT];
            powerdown_stretch_reg <= RST_GAP9_FCTR[FCTR_BIT];
            slot_c12_reg <= RST_SLOT_C12;
            slot_c34_reg <= RST_SLOT_C34;
        end else if (i_reg_req.wr) begin
            unique case (i_reg_req.addr)
                ADDR_GAPS_1_8: gaps_reg <= i_reg_req.wdata;
                ADDR_GAP9_FCTR: begin
                    gap9_reg <= i_reg_req.wdata[GAP9_BIT];
                    powerdown_stretch_reg <= i_reg_req.wdata[FCTR_BIT];
                end
                ADDR_SLOT_C12: slot_c12_reg <= i_reg_req.wdata;
                ADDR_SLOT_C34: slot_c34_reg <= i_reg_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_req.rd) begin
            unique case (i_reg_req.addr)
                ADDR_GAPS_1_8: o_reg_rdata <= gaps_reg;
                ADDR_GAP9_FCTR: o_reg_rdata <= {powerdown_stretch_reg, 6'h00, gap9_reg};
                ADDR_SLOT_C12: o_reg_rdata <= slot_c12_reg;
                ADDR_SLOT_C34: o_reg_rdata <= slot_c34_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot decode, one per converter
    generate
        for (genvar c = 0; c < NUM_CONV; c++) begin : g_slot
            logic [SLOT_W-1:0] code;
            assign code = slots[c*SLOT_W +: SLOT_W];
            assign hit[c] = (code >= SLOT_MIN) && (code <= SLOT_MAX) && (code == cur_reg);
        end
    endgenerate

    // Delay after strobe n (up) or before strobe n (down)
    always_comb begin
        gap_idx = down_reg ? (cur_reg - 4'h2) : (cur_reg - 4'h1);
        if (gap_sel[gap_idx]) begin
            ms_next = (down_reg && powerdown_stretch_reg) ? GAP_LONG_PD_MS : GAP_LONG_MS;
        end else begin
            ms_next = (down_reg && powerdown_stretch_reg) ? GAP_SHORT_PD_MS : GAP_SHORT_MS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step sequencing
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg <= SQ_IDLE;
            down_reg <= 1'b0;
            cur_reg <= STROBE_FIRST;
            ms_reg <= 6'h00;
            div_reg <= '0;
        end else begin
            unique case (state_reg)
                SQ_IDLE: begin
                    if (i_pu_start) begin
                        down_reg <= 1'b0;
                        cur_reg <= STROBE_FIRST;
                        state_reg <= SQ_STROBE;
                    end else if (i_pd_start) begin
                        down_reg <= 1'b1;
                        cur_reg <= STROBE_LAST;
                        state_reg <= SQ_STROBE;
                    end
                end
                SQ_STROBE: begin
                    div_reg <= '0;
                    if (cur_reg == (down_reg ? STROBE_FIRST : STROBE_LAST)) begin
                        state_reg <= SQ_IDLE;
                    end else begin
                        ms_reg <= ms_next;
                        state_reg <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    div_reg <= tick ? '0 : div_reg + 1'b1;
                    if (tick) begin
                        ms_reg <= ms_reg - 6'h01;
                        if (ms_reg == 6'h01) begin
                            cur_reg <= down_reg ? cur_reg - 4'h1 : cur_reg + 4'h1;
                            state_reg <= SQ_STROBE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe and rail outputs
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_strobe_pulse <= 1'b0;
            o_strobe_num <= 4'h0;
            o_rail_en <= '0;
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_reg != SQ_IDLE) || i_pu_start || i_pd_start;
            o_strobe_pulse <= 1'b0;
            if (state_reg == SQ_STROBE && !(i_freshness_seal_flag && cur_reg <= STROBE_SEALED_MAX)) begin
                o_strobe_pulse <= 1'b1;
                o_strobe_num <= cur_reg;
                o_rail_en <= down_reg ? (o_rail_en & ~hit) : (o_rail_en | hit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    strobe_range_a: assert property (o_strobe_pulse |-> o_strobe_num >= STROBE_FIRST && o_strobe_num <= STROBE_LAST)
        else $error("strobe number out of range");
    strobe_order_a: assert property (state_reg == SQ_WAIT && tick && ms_reg == 6'h01 && !down_reg
        |=> cur_reg == $past(cur_reg) + 4'h1)
        else $error("power-up strobe skipped or repeated");
    up_gap_len_a: assert property (state_reg == SQ_STROBE && !down_reg && cur_reg != STROBE_LAST
        |=> ms_reg == (gap_sel[$past(cur_reg) - 4'h1] ? GAP_LONG_MS : GAP_SHORT_MS))
        else $error("power-up delay length wrong");
    pd_gap_len_a: assert property (state_reg == SQ_STROBE && down_reg && powerdown_stretch_reg
        && cur_reg != STROBE_FIRST |=> ms_reg == GAP_SHORT_PD_MS || ms_reg == GAP_LONG_PD_MS)
        else $error("power-down stretch not applied");
    gap9_field_a: assert property (i_reg_req.wr && i_reg_req.addr == ADDR_GAP9_FCTR
        |=> gap9_reg == $past(i_reg_req.wdata[GAP9_BIT]))
        else $error("ninth delay bit not stored");
    reset_cfg_a: assert property ($past(i_sys_rst) |-> gaps_reg == RST_GAPS_1_8 && slot_c12_reg == RST_SLOT_C12
        && slot_c34_reg == RST_SLOT_C34 && gap9_reg == RST_GAP9_FCTR[GAP9_BIT])
        else $error("configuration reset value wrong");
    reserved_zero_a: assert property (i_reg_req.rd && i_reg_req.addr == ADDR_GAP9_FCTR
        |=> o_reg_rdata[6:1] == 6'h00)
        else $error("reserved bits read nonzero");
    rail_on_a: assert property (state_reg == SQ_STROBE && !down_reg && hit[0]
        && !(i_freshness_seal_flag && cur_reg <= STROBE_SEALED_MAX) |=> o_rail_en[0])
        else $error("rail not enabled at its strobe");
    bad_slot_a: assert property ($rose(o_rail_en[0]) |-> slot_c12_reg[3:0] >= SLOT_MIN
        && slot_c12_reg[3:0] <= SLOT_MAX)
        else $error("rail enabled by an unused slot code");
    seal_skip_a: assert property (state_reg == SQ_STROBE && i_freshness_seal_flag
        && cur_reg <= STROBE_SEALED_MAX |=> !o_strobe_pulse)
        else $error("sealed strobe issued");

    up_done_c: cover property (o_strobe_pulse && !down_reg && o_strobe_num == STROBE_LAST);
    down_done_c: cover property (o_strobe_pulse && down_reg && o_strobe_num == STROBE_FIRST);
    stretch_c: cover property (state_reg == SQ_WAIT && ms_reg == GAP_LONG_PD_MS);
    sealed_c: cover property (state_reg == SQ_STROBE && i_freshness_seal_flag && cur_reg == STROBE_FIRST);
endmodule
`default_nettype wire

// ### rsseq_pkg.sv
// Package for the rail strobe sequencer: register map, field layout, timing
package rsseq_pkg;
    // Register subaddresses
    localparam logic [7:0] ADDR_GAPS_1_8 = 8'h20;
    localparam logic [7:0] ADDR_GAP9_FCTR = 8'h21;
    localparam logic [7:0] ADDR_SLOT_C12 = 8'h22;
    localparam logic [7:0] ADDR_SLOT_C34 = 8'h23;
    // Reset values
    localparam logic [7:0] RST_GAPS_1_8 = 8'h06;
    localparam logic [7:0] RST_GAP9_FCTR = 8'h00;
    localparam logic [7:0] RST_SLOT_C12 = 8'h94;
    localparam logic [7:0] RST_SLOT_C34 = 8'h8a;
    // Field positions
    localparam int FCTR_BIT = 7;
    localparam int GAP9_BIT = 0;
    localparam int SLOT_W = 4;
    localparam int NUM_CONV = 4;
    localparam int NUM_GAPS = 9;
    // Strobe numbering and valid slot codes
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_LAST = 4'ha;
    localparam logic [3:0] STROBE_SEALED_MAX = 4'h2;
    localparam logic [3:0] SLOT_MIN = 4'h3;
    localparam logic [3:0] SLOT_MAX = 4'ha;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_IN_NS = 1000000;
    localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    localparam logic [5:0] GAP_SHORT_MS = 6'h02;
    localparam logic [5:0] GAP_LONG_MS = 6'h05;
    localparam logic [5:0] GAP_SHORT_PD_MS = 6'h14;
    localparam logic [5:0] GAP_LONG_PD_MS = 6'h32;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsseq_reg_req_s;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_STROBE,
        SQ_WAIT
    } rsseq_state_e;
endpackage

// ### rsseq_rail_model.sv
// Model of the rail enable inputs: each rail ramps up after a short soft start
`timescale 1ns/1ps
`default_nettype none
module rsseq_rail_model
    import rsseq_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Enables from the sequencer
    input wire logic [NUM_CONV-1:0] i_rail_en,
    // Rail output good
    output logic [NUM_CONV-1:0] o_rail_on
);
    logic [1:0] ramp_reg [NUM_CONV];

    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CONV; c++) begin
            if (i_sys_rst || !i_rail_en[c]) begin
                ramp_reg[c] <= 2'h0;
                o_rail_on[c] <= 1'b0;
            end else if (ramp_reg[c] == 2'h3) begin
                o_rail_on[c] <= 1'b1;
            end else begin
                ramp_reg[c] <= ramp_reg[c] + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### rail_strobe_sequencer_tb_top.sv
// Testbench for the rail strobe sequencer: registers, strobe timing, rail enables
`timescale 1ns/1ps
`default_nettype none
module rail_strobe_sequencer_tb_top;
    import rsseq_pkg::*;
    localparam int CM = 4;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    rsseq_reg_req_s req = '0;
    logic pu = 1'b0;
    logic pd = 1'b0;
    logic seal = 1'b0;
    logic [7:0] rdata;
    logic busy;
    logic spulse;
    logic [3:0] snum;
    logic [NUM_CONV-1:0] rails;
    logic [NUM_CONV-1:0] rails_on;
    logic [NUM_CONV-1:0] erails = '0;
    logic [8:0] gsel;
    logic fctr;
    logic [3:0] slot [4];
    int err_total = 0;
    int n_checks = 0;
    int ticks = 0;

    always #25 i_core_clk = ~i_core_clk;

    rsseq_sequencer #(.CYC_MS(CM)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_req(req),
        .o_reg_rdata(rdata), .i_pu_start(pu), .i_pd_start(pd), .i_freshness_seal_flag(seal),
        .o_busy(busy), .o_strobe_pulse(spulse), .o_strobe_num(snum), .o_rail_en(rails));
    rsseq_rail_model model (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rail_en(rails),
        .o_rail_on(rails_on));

    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        ticks++;
        if (ticks == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_core_clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_core_clk);
        req <= '0;
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask

    ////////////////////////////////////////////////////////////////
    // One sequence: check every strobe number, gap and rail state
    task automatic run(input logic down, input int npulse);
        int n;
        int cyc;
        int last;
        int s;
        int ms;
        n = 0;
        cyc = 0;
        last = 0;
        @(posedge i_core_clk);
        pu <= !down;
        pd <= down;
        @(posedge i_core_clk);
        pu <= 1'b0;
        pd <= 1'b0;
        do begin
            @(posedge i_core_clk);
            #1;
            cyc++;
            if (spulse === 1'b1) begin
                s = down ? 10 - n : 1 + n;
                chk({12'h000, snum}, 16'(s));
                if (n > 0) begin
                    ms = gsel[(down ? s : s - 1) - 1] ? 5 : 2;
                    if (down && fctr) ms = ms * 10;
                    chk(16'(cyc - last), 16'(1 + ms * CM));
                end
                for (int c = 0; c < 4; c++) begin
                    if (slot[c] >= SLOT_MIN && slot[c] <= SLOT_MAX && slot[c] == 4'(s)) erails[c] = !down;
                end
                chk({12'h000, rails}, {12'h000, erails});
                last = cyc;
                n++;
            end
        end while (busy !== 1'b0 && cyc < 3000);
        chk(16'(n), 16'(npulse));
        repeat (6) @(posedge i_core_clk);
        #1;
        chk({12'h000, rails_on}, {12'h000, erails});
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        rd(ADDR_GAPS_1_8, 8'h06);
        rd(ADDR_GAP9_FCTR, 8'h00);
        rd(ADDR_SLOT_C12, 8'h94);
        rd(ADDR_SLOT_C34, 8'h8a);
        rd(8'h30, 8'h00);
        wr(ADDR_GAPS_1_8, 8'ha5);
        wr(ADDR_GAP9_FCTR, 8'hff);
        wr(ADDR_SLOT_C12, 8'ha3);
        wr(ADDR_SLOT_C34, 8'hb2);
        rd(ADDR_GAP9_FCTR, 8'h81);
        rd(ADDR_SLOT_C12, 8'ha3);
        rd(ADDR_SLOT_C34, 8'hb2);
        gsel = 9'h1a5;
        fctr = 1'b1;
        slot = '{4'h3, 4'ha, 4'h2, 4'hb};
        run(1'b0, 10);
        @(posedge i_core_clk);
        seal <= 1'b1;
        run(1'b1, 8);
        wr(ADDR_GAP9_FCTR, 8'h01);
        rd(ADDR_GAP9_FCTR, 8'h01);
        fctr = 1'b0;
        @(posedge i_core_clk);
        seal <= 1'b0;
        run(1'b0, 10);
        run(1'b1, 10);
        conclude();
    end
endmodule
`default_nettype wire
